// file: inc/bbr_defs.svh
// Purpose: Constants for the byte-wide bus read cycle master.
// Assumes: Processor clock i_ref_clk at 40 MHz; one bus half-state per clock edge pair is mapped to one clock.
// Notes: Space and size codes and the mode count used by the master live here; state and end codes are in bbr_pkg; the test files write their own literals.
`ifndef BBR_DEFS_SVH
`define BBR_DEFS_SVH

`define BBR_ADDR_W 24
`define BBR_SPACE_RESERVED0 3'h0
`define BBR_SPACE_USER_DATA 3'h1
`define BBR_SPACE_USER_PROG 3'h2
`define BBR_SPACE_RESERVED3 3'h3
`define BBR_SPACE_RESERVED4 3'h4
`define BBR_SPACE_SUPER_DATA 3'h5
`define BBR_SPACE_SUPER_PROG 3'h6
`define BBR_SPACE_PROC 3'h7
`define BBR_SIZE_BYTE 2'h0
`define BBR_SIZE_WORD 2'h1
`define BBR_SIZE_LONG 2'h2
`define BBR_MODE_STABLE_CLKS 2'h2

`endif

// file: inc/bbr_pkg.sv
// Purpose: Types for the byte-wide bus read cycle master.
// Assumes: Nothing beyond the constants header.
// Notes: Nothing is imported; users write bbr_pkg::name.
package bbr_pkg;

  typedef enum logic [3:0]
  {
    BBR_IDLE = 4'h0,
    BBR_S0 = 4'h1,
    BBR_S1 = 4'h2,
    BBR_S2 = 4'h3,
    BBR_S3 = 4'h4,
    BBR_S4 = 4'h5,
    BBR_S5 = 4'h6,
    BBR_S6 = 4'h7,
    BBR_S7 = 4'h8,
    BBR_S8 = 4'h9,
    BBR_S9 = 4'ha
  } bbr_state_t;

  typedef enum logic [1:0]
  {
    BBR_END_ACK = 2'h0,
    BBR_END_FAULT = 2'h1,
    BBR_END_RETRY = 2'h2,
    BBR_END_PERIPH = 2'h3
  } bbr_end_t;

endpackage

// file: src/bbr_buf.sv
// Purpose: Two-entry buffer between the read sequencer and the receiver of assembled data.
// Assumes: Single clock, asynchronous active-high reset.
// Notes: Stalls on the drain side fill it, and in_ready then stalls the sequencer.
`timescale 1ns/1ps
module bbr_buf
(
  input wire logic i_ref_clk,     // Processor clock.
  input wire logic i_reset,       // Asynchronous reset, active high.
  input wire logic i_in_valid,    // Word offered.
  output logic o_in_ready,        // Room for a word.
  input wire logic [33:0] i_in_data, // Word with status bits.
  output logic o_out_valid,       // Word available.
  input wire logic i_out_ready,   // Drain takes word.
  output logic [33:0] o_out_data  // Oldest word.
);

  logic [33:0] mem [0:1];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;

  assign o_in_ready = (count != 2'h2);
  assign o_out_valid = (count != 2'h0);
  assign o_out_data = mem[rd_ptr];

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      mem[0] <= 34'h0;
      mem[1] <= 34'h0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      if (push)
        mem[wr_ptr] <= i_in_data;
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

// file: src/bbr_master.sv
// Purpose: Bus master for byte-wide asynchronous read cycles, including space code and byte assembly.
// Assumes: Slave inputs are asynchronous pins and pass two flip-flops; each S state lasts one clock here.
// Notes: Falling-edge sampling is mapped to the clock that closes the state; wait states are whole clocks.
`timescale 1ns/1ps
`include "bbr_defs.svh"

module bbr_master
(
  input wire logic i_ref_clk,               // Processor clock, 40 MHz.
  input wire logic i_reset,                 // Asynchronous reset, active high.
  input wire logic i_width_select_n,        // Width-select pin, low selects byte-wide mode.
  input wire logic i_req_valid,             // Read request.
  output logic o_req_ready,                 // Request accepted.
  input wire logic [23:0] i_req_addr,       // Start byte address.
  input wire logic [1:0] i_req_size,        // Byte, word or long word.
  input wire logic [2:0] i_req_space,       // Space code for the access.
  output logic o_rsp_valid,                 // Assembled data available.
  input wire logic i_rsp_ready,             // Receiver takes data.
  output logic [31:0] o_rsp_data,           // Assembled data, right aligned.
  output logic o_rsp_fault,                 // Access ended in bus fault exception.
  output logic o_rsp_periph,                // Access ended in slow-peripheral conversion.
  output logic o_byte_mode,                 // Byte-wide mode latched after reset release.
  output logic [2:0] o_space_code,          // Space code pins.
  output logic o_space_code_oe,             // Space code drive enable.
  output logic [23:0] o_addr,               // Address pins with byte select bit.
  output logic o_addr_oe,                   // Address drive enable.
  output logic o_read_write,                // High for read.
  output logic o_address_strobe_n,          // Address strobe, active low.
  output logic o_lower_byte_strobe_n,       // Lower or single data strobe, active low.
  output logic o_upper_byte_strobe_n,       // Upper byte strobe, active low.
  input wire logic [15:0] i_data,           // Data lanes; upper lanes ignored.
  input wire logic i_transfer_acknowledge_n, // Transfer acknowledge, active low.
  input wire logic i_bus_fault_input_n,     // Bus fault, active low.
  input wire logic i_slow_peripheral_select_n, // Slow-peripheral select, active low.
  input wire logic i_halt_n                 // Halt input, active low.
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [7:0] data_s1;
  logic [7:0] data_s2;

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      sync1 <= 4'hf;
      sync2 <= 4'hf;
      data_s1 <= 8'h00;
      data_s2 <= 8'h00;
    end
    else
    begin
      sync1 <= {i_transfer_acknowledge_n, i_bus_fault_input_n, i_slow_peripheral_select_n, i_halt_n};
      sync2 <= sync1;
      data_s1 <= i_data[7:0];
      data_s2 <= data_s1;
    end
  end

  wire ack = ~sync2[3];
  wire fault = ~sync2[2];
  wire periph = ~sync2[1];
  wire halt = ~sync2[0];

  // ------------------------------------------------------------
  // Width select captured after reset release
  // ------------------------------------------------------------
  logic [1:0] mode_cnt;
  logic mode_done;
  logic width_s1;
  logic width_s2;

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      width_s1 <= 1'b1;
      width_s2 <= 1'b1;
    end
    else
    begin
      width_s1 <= i_width_select_n;
      width_s2 <= width_s1;
    end
  end

  // The pin must be stable for two clocks after release, so it is taken then.
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      mode_cnt <= 2'h0;
      mode_done <= 1'b0;
      o_byte_mode <= 1'b0;
    end
    else if (!mode_done)
    begin
      mode_cnt <= mode_cnt + 2'h1;
      if (mode_cnt == `BBR_MODE_STABLE_CLKS)
      begin
        mode_done <= 1'b1;
        o_byte_mode <= ~width_s2;
      end
    end
  end

  // ------------------------------------------------------------
  // Byte sequencing helpers
  // ------------------------------------------------------------
  function automatic logic [2:0] bbr_byte_count(input logic [1:0] size, input logic byte_mode);
    if (!byte_mode)
      bbr_byte_count = 3'h1;
    else if (size == `BBR_SIZE_LONG)
      bbr_byte_count = 3'h4;
    else if (size == `BBR_SIZE_WORD)
      bbr_byte_count = 3'h2;
    else
      bbr_byte_count = 3'h1;
  endfunction

  function automatic logic [31:0] bbr_place(input logic [31:0] acc, input logic [7:0] b, input logic [1:0] lane);
    logic [31:0] r;
    r = acc;
    r[{lane, 3'h0} +: 8] = b;
    bbr_place = r;
  endfunction

  // ------------------------------------------------------------
  // Cycle state machine
  // ------------------------------------------------------------
  bbr_pkg::bbr_state_t state;
  bbr_pkg::bbr_state_t next_state;
  bbr_pkg::bbr_end_t end_kind;
  logic [23:0] cur_addr;
  logic [2:0] cur_space;
  logic [1:0] cur_size;
  logic [2:0] bytes_left;
  logic [1:0] byte_idx;
  logic [31:0] acc;
  logic acc_fault;
  logic acc_periph;
  logic push;

  wire buf_ready;
  wire start = (state == bbr_pkg::BBR_IDLE) && i_req_valid && mode_done && buf_ready;
  wire term_seen = ack || fault || periph;
  // Lanes are numbered from the most significant byte of the access down.
  wire [1:0] lane = 2'(bbr_byte_count(cur_size, 1'b1) - 3'h1 - {1'b0, byte_idx});
  wire last_byte = (bytes_left == 3'h1);
  wire fault_only = fault && !ack;
  wire strobes_on = (state == bbr_pkg::BBR_S2) || (state == bbr_pkg::BBR_S3) || (state == bbr_pkg::BBR_S4) ||
    (state == bbr_pkg::BBR_S5) || (state == bbr_pkg::BBR_S6);

  assign o_req_ready = start;

  always_comb
  begin
    next_state = state;
    case (state)
      bbr_pkg::BBR_IDLE:
        if (start)
          next_state = bbr_pkg::BBR_S0;
      bbr_pkg::BBR_S0:
        next_state = bbr_pkg::BBR_S1;
      bbr_pkg::BBR_S1:
        next_state = bbr_pkg::BBR_S2;
      bbr_pkg::BBR_S2:
        next_state = bbr_pkg::BBR_S3;
      bbr_pkg::BBR_S3:
        next_state = bbr_pkg::BBR_S4;
      bbr_pkg::BBR_S4:
        if (term_seen)
          next_state = bbr_pkg::BBR_S5;
      bbr_pkg::BBR_S5:
        next_state = bbr_pkg::BBR_S6;
      bbr_pkg::BBR_S6:
        next_state = bbr_pkg::BBR_S7;
      bbr_pkg::BBR_S7:
        if (end_kind == bbr_pkg::BBR_END_FAULT || end_kind == bbr_pkg::BBR_END_RETRY)
          next_state = bbr_pkg::BBR_S8;
        else if (end_kind == bbr_pkg::BBR_END_ACK && !last_byte)
          next_state = bbr_pkg::BBR_S0;
        else
          next_state = bbr_pkg::BBR_IDLE;
      bbr_pkg::BBR_S8:
        next_state = bbr_pkg::BBR_S9;
      bbr_pkg::BBR_S9:
        if (end_kind == bbr_pkg::BBR_END_RETRY)
          next_state = bbr_pkg::BBR_S0;
        else
          next_state = bbr_pkg::BBR_IDLE;
      default:
        next_state = bbr_pkg::BBR_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      state <= bbr_pkg::BBR_IDLE;
    else
      state <= next_state;
  end

  // Termination kind is recorded on the S4 clock that sees a termination input.
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      end_kind <= bbr_pkg::BBR_END_ACK;
    else if (state == bbr_pkg::BBR_S4 && term_seen)
    begin
      if (fault_only && halt)
        end_kind <= bbr_pkg::BBR_END_RETRY;
      else if (fault_only)
        end_kind <= bbr_pkg::BBR_END_FAULT;
      else if (ack)
        end_kind <= bbr_pkg::BBR_END_ACK;
      else
        end_kind <= bbr_pkg::BBR_END_PERIPH;
    end
  end

  // ------------------------------------------------------------
  // Access registers and byte assembly
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cur_addr <= 24'h000000;
      cur_space <= `BBR_SPACE_RESERVED0;
      cur_size <= `BBR_SIZE_BYTE;
      bytes_left <= 3'h0;
      byte_idx <= 2'h0;
    end
    else if (start)
    begin
      cur_addr <= i_req_addr;
      cur_space <= i_req_space;
      cur_size <= i_req_size;
      bytes_left <= bbr_byte_count(i_req_size, o_byte_mode);
      byte_idx <= 2'h0;
    end
    else if (state == bbr_pkg::BBR_S7 && end_kind == bbr_pkg::BBR_END_ACK && !last_byte)
    begin
      cur_addr <= cur_addr + 24'h000001;
      bytes_left <= bytes_left - 3'h1;
      byte_idx <= byte_idx + 2'h1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      acc <= 32'h00000000;
      acc_fault <= 1'b0;
      acc_periph <= 1'b0;
    end
    else if (start)
    begin
      acc <= 32'h00000000;
      acc_fault <= 1'b0;
      acc_periph <= 1'b0;
    end
    else if (state == bbr_pkg::BBR_S6 && end_kind == bbr_pkg::BBR_END_ACK && o_read_write)
      acc <= bbr_place(acc, data_s2, lane);
    else if (state == bbr_pkg::BBR_S9 && end_kind == bbr_pkg::BBR_END_FAULT)
      acc_fault <= 1'b1;
    else if (state == bbr_pkg::BBR_S7 && end_kind == bbr_pkg::BBR_END_PERIPH)
      acc_periph <= 1'b1;
  end

  assign push = ((state == bbr_pkg::BBR_S7) && (end_kind == bbr_pkg::BBR_END_ACK) && last_byte) ||
    ((state == bbr_pkg::BBR_S7) && (end_kind == bbr_pkg::BBR_END_PERIPH)) ||
    ((state == bbr_pkg::BBR_S9) && (end_kind == bbr_pkg::BBR_END_FAULT));

  wire [31:0] push_data = (end_kind == bbr_pkg::BBR_END_ACK) ? acc : 32'h00000000;
  wire push_fault = (end_kind == bbr_pkg::BBR_END_FAULT);
  wire push_periph = (end_kind == bbr_pkg::BBR_END_PERIPH);

  bbr_buf u_buf
  (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_in_valid(push),
    .o_in_ready(buf_ready),
    .i_in_data({push_fault, push_periph, push_data}),
    .o_out_valid(o_rsp_valid),
    .i_out_ready(i_rsp_ready),
    .o_out_data({o_rsp_fault, o_rsp_periph, o_rsp_data})
  );

  // ------------------------------------------------------------
  // Bus pin registers
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_space_code <= `BBR_SPACE_RESERVED0;
      o_space_code_oe <= 1'b0;
      o_addr <= 24'h000000;
      o_addr_oe <= 1'b0;
      o_read_write <= 1'b1;
      o_address_strobe_n <= 1'b1;
      o_lower_byte_strobe_n <= 1'b1;
      o_upper_byte_strobe_n <= 1'b1;
    end
    else
    begin
      o_upper_byte_strobe_n <= 1'b1;
      if (next_state == bbr_pkg::BBR_S0)
      begin
        o_space_code <= start ? i_req_space : cur_space;
        o_space_code_oe <= 1'b1;
        o_read_write <= 1'b1;
      end
      else if (next_state == bbr_pkg::BBR_IDLE)
        o_space_code_oe <= 1'b0;
      if (next_state == bbr_pkg::BBR_S1)
      begin
        o_addr <= cur_addr;
        o_addr_oe <= 1'b1;
      end
      else if (next_state == bbr_pkg::BBR_S8 || next_state == bbr_pkg::BBR_S0 || next_state == bbr_pkg::BBR_IDLE)
        o_addr_oe <= 1'b0;
      // Strobes are held through S3 to S6 and drop entering S7.
      o_address_strobe_n <= ~(next_state == bbr_pkg::BBR_S2 || (strobes_on && next_state != bbr_pkg::BBR_S7));
      o_lower_byte_strobe_n <= ~(next_state == bbr_pkg::BBR_S2 ||
        (strobes_on && next_state != bbr_pkg::BBR_S7));
    end
  end

endmodule

// file: test/bbr_monitor.sv
// Purpose: Bus timing checks for the byte read master.
// Assumes: One clock, asynchronous reset active high.
// Notes: Bound to every bbr_master instance.
`timescale 1ns/1ps
// ----------------------------------------
// Checker
// ----------------------------------------
module bbr_monitor
(
  input wire logic i_ref_clk, // Clock.
  input wire logic i_reset, // Reset.
  input wire logic o_byte_mode, // Byte mode.
  input wire logic [2:0] o_space_code, // Space code.
  input wire logic o_space_code_oe, // Space code enable.
  input wire logic [23:0] o_addr, // Address.
  input wire logic o_addr_oe, // Address enable.
  input wire logic o_read_write, // Read/write.
  input wire logic o_address_strobe_n, // Address strobe.
  input wire logic o_lower_byte_strobe_n, // Data strobe.
  input wire logic o_upper_byte_strobe_n, // Upper strobe.
  input wire logic o_rsp_valid, // Result valid.
  input wire logic o_rsp_fault, // Fault result.
  input wire logic o_rsp_periph, // Peripheral result.
  input wire logic i_transfer_acknowledge_n, // Acknowledge.
  input wire logic i_bus_fault_input_n, // Fault.
  input wire logic i_slow_peripheral_select_n // Peripheral select.
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);
  property p_upper_idle;
    o_byte_mode |-> o_upper_byte_strobe_n;
  endproperty
  a_upper_idle: assert property (p_upper_idle)
    else $error("upper strobe active in byte mode");
  property p_one_strobe;
    o_byte_mode |-> (o_lower_byte_strobe_n == o_address_strobe_n);
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("data strobe differs from address strobe");
  property p_space_hold;
    !o_address_strobe_n && !$past(o_address_strobe_n) |-> o_space_code_oe && $stable(o_space_code);
  endproperty
  a_space_hold: assert property (p_space_hold)
    else $error("space code moved under address strobe");
  property p_start_order;
    $fell(o_address_strobe_n) |-> o_read_write && $past(o_addr_oe) && $past(o_space_code_oe, 2);
  endproperty
  a_start_order: assert property (p_start_order)
    else $error("strobe before space code or address");
  property p_addr_hold;
    !o_address_strobe_n |-> o_addr_oe && $stable(o_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved under strobe");
  property p_low_run;
    $fell(o_address_strobe_n) |=> !o_address_strobe_n [*4];
  endproperty
  a_low_run: assert property (p_low_run)
    else $error("strobe ended before state seven");
  property p_release;
    $rose(o_address_strobe_n) |-> ##[0:1] !o_addr_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("address not released");
  property p_term_cause;
    $rose(o_address_strobe_n) |-> !($past(i_transfer_acknowledge_n, 2) && $past(i_bus_fault_input_n, 2)
      && $past(i_slow_peripheral_select_n, 2));
  endproperty
  a_term_cause: assert property (p_term_cause)
    else $error("cycle ended without termination");
  property p_bound;
    $fell(o_address_strobe_n) |-> ##[5:60] $rose(o_address_strobe_n);
  endproperty
  a_bound: assert property (p_bound)
    else $error("cycle did not end");
  c_fault: cover property (o_rsp_valid && o_rsp_fault);
  c_periph: cover property (o_rsp_valid && o_rsp_periph);
  c_wait: cover property (!o_address_strobe_n [*8]);
endmodule

bind bbr_master bbr_monitor u_bbr_monitor (.i_ref_clk, .i_reset, .o_byte_mode, .o_space_code, .o_space_code_oe,
  .o_addr, .o_addr_oe, .o_read_write, .o_address_strobe_n, .o_lower_byte_strobe_n, .o_upper_byte_strobe_n,
  .o_rsp_valid, .o_rsp_fault, .o_rsp_periph, .i_transfer_acknowledge_n, .i_bus_fault_input_n,
  .i_slow_peripheral_select_n);

// file: test/bbr_slave.sv
// Purpose: Memory slave on the byte read bus.
// Assumes: Answers after a set number of clocks with the strobes low.
// Notes: Byte value is the low address byte xored with hexadecimal 96.
`timescale 1ns/1ps
// ----------------------------------------
// Slave model
// ----------------------------------------
module bbr_slave
(
  input wire logic i_ref_clk, // Clock.
  input wire logic i_reset, // Reset.
  input wire logic [1:0] i_mode, // 0 ack, 1 fault, 2 peripheral, 3 fault with halt once.
  input wire logic [3:0] i_delay, // Clocks from strobe to answer.
  input wire logic [23:0] i_addr, // Address pins.
  input wire logic [2:0] i_space_code, // Space code pins.
  input wire logic i_read_write, // Read/write.
  input wire logic i_address_strobe_n, // Address strobe.
  input wire logic i_lower_byte_strobe_n, // Data strobe.
  output logic [15:0] o_data, // Data lanes.
  output logic o_transfer_acknowledge_n, // Acknowledge.
  output logic o_bus_fault_input_n, // Fault.
  output logic o_slow_peripheral_select_n, // Peripheral select.
  output logic o_halt_n, // Halt.
  output logic [2:0] o_seen_space // Space code seen with strobe.
);
  logic [3:0] wait_cnt;
  logic faulted;
  wire selected = !i_address_strobe_n && !i_lower_byte_strobe_n && i_read_write;
  wire answer = selected && (wait_cnt >= i_delay);
  wire use_ack = (i_mode == 2'h0) || ((i_mode == 2'h3) && faulted);
  wire use_fault = (i_mode == 2'h1) || ((i_mode == 2'h3) && !faulted);
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_data <= 16'ha5c3;
      o_transfer_acknowledge_n <= 1'b1;
      o_bus_fault_input_n <= 1'b1;
      o_slow_peripheral_select_n <= 1'b1;
      o_halt_n <= 1'b1;
      o_seen_space <= 3'h0;
      wait_cnt <= 4'h0;
      faulted <= 1'b0;
    end
    else
    begin
      o_data[15:8] <= o_data[15:8] + 8'h01;
      if (answer && use_ack)
        o_data[7:0] <= i_addr[7:0] ^ 8'h96;
      else if (!selected)
        o_data[7:0] <= ~o_data[7:0];
      wait_cnt <= (selected && wait_cnt != 4'hf) ? wait_cnt + 4'h1 : (selected ? wait_cnt : 4'h0);
      o_transfer_acknowledge_n <= !(answer && use_ack);
      o_bus_fault_input_n <= !(answer && use_fault);
      o_halt_n <= !(answer && (i_mode == 2'h3) && !faulted);
      o_slow_peripheral_select_n <= !(answer && (i_mode == 2'h2));
      if (i_mode != 2'h3)
        faulted <= 1'b0;
      else if (!selected && !o_bus_fault_input_n)
        faulted <= 1'b1;
      if (selected)
        o_seen_space <= i_space_code;
    end
  end
endmodule

// file: test/tb_byte_bus_read_cycle_master.sv
// Purpose: Self-checking bench for the byte read master.
// Assumes: Slave model answers on the pins.
// Notes: Each scenario is a task that judges its own results.
`timescale 1ns/1ps
// ----------------------------------------
// Bench
// ----------------------------------------
module tb_byte_bus_read_cycle_master;
  logic i_ref_clk, i_reset, i_width_select_n, i_req_valid, i_rsp_ready;
  logic as_q = 1'b1;
  logic [23:0] i_req_addr, o_addr;
  logic [1:0] i_req_size, mode;
  logic [2:0] i_req_space, o_space_code, seen_space;
  logic [3:0] delay;
  logic o_req_ready, o_rsp_valid, o_rsp_fault, o_rsp_periph, o_byte_mode, o_space_code_oe, o_addr_oe;
  logic o_read_write, o_address_strobe_n, o_lower_byte_strobe_n, o_upper_byte_strobe_n;
  logic ack_n, fault_n, periph_n, halt_n;
  logic [31:0] o_rsp_data;
  logic [15:0] data;
  logic [7:0] n_cyc = 8'h00;
  int n_fail, checks;
  bbr_master u_bbr_master (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_width_select_n(i_width_select_n),
    .i_req_valid(i_req_valid), .o_req_ready(o_req_ready), .i_req_addr(i_req_addr), .i_req_size(i_req_size),
    .i_req_space(i_req_space), .o_rsp_valid(o_rsp_valid), .i_rsp_ready(i_rsp_ready), .o_rsp_data(o_rsp_data),
    .o_rsp_fault(o_rsp_fault), .o_rsp_periph(o_rsp_periph), .o_byte_mode(o_byte_mode),
    .o_space_code(o_space_code), .o_space_code_oe(o_space_code_oe), .o_addr(o_addr), .o_addr_oe(o_addr_oe),
    .o_read_write(o_read_write), .o_address_strobe_n(o_address_strobe_n),
    .o_lower_byte_strobe_n(o_lower_byte_strobe_n), .o_upper_byte_strobe_n(o_upper_byte_strobe_n),
    .i_data(data), .i_transfer_acknowledge_n(ack_n), .i_bus_fault_input_n(fault_n),
    .i_slow_peripheral_select_n(periph_n), .i_halt_n(halt_n));
  bbr_slave u_bbr_slave (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_mode(mode), .i_delay(delay),
    .i_addr(o_addr), .i_space_code(o_space_code), .i_read_write(o_read_write),
    .i_address_strobe_n(o_address_strobe_n), .i_lower_byte_strobe_n(o_lower_byte_strobe_n), .o_data(data),
    .o_transfer_acknowledge_n(ack_n), .o_bus_fault_input_n(fault_n), .o_slow_peripheral_select_n(periph_n),
    .o_halt_n(halt_n), .o_seen_space(seen_space));

  initial
  begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  // Counts the starts of bus cycles.
  always @(posedge i_ref_clk)
  begin
    as_q <= o_address_strobe_n;
    if (as_q === 1'b1 && o_address_strobe_n === 1'b0)
      n_cyc <= n_cyc + 8'h01;
  end

  function automatic logic [31:0] exp_data(input logic [23:0] a, input logic [1:0] sz);
    logic [7:0] b0, b1, b2, b3;
    b0 = a[7:0] ^ 8'h96;
    b1 = (a[7:0] + 8'h01) ^ 8'h96;
    b2 = (a[7:0] + 8'h02) ^ 8'h96;
    b3 = (a[7:0] + 8'h03) ^ 8'h96;
    return (sz == 2'h0) ? {24'h0, b0} : ((sz == 2'h1) ? {16'h0, b0, b1} : {b0, b1, b2, b3});
  endfunction

  task automatic results;
    if (n_fail == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [33:0] exp, input logic [33:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask

  task automatic timeout(input string name);
    $display("Error %s expected done seen timeout", name);
    n_fail++;
    results;
  endtask

  task automatic tick;
    @(posedge i_ref_clk);
    #1;
  endtask

  task automatic send(input logic [23:0] a, input logic [1:0] sz, input logic [2:0] sp, input int lim,
    output logic ok);
    i_req_addr = a;
    i_req_size = sz;
    i_req_space = sp;
    i_req_valid = 1'b1;
    ok = 1'b0;
    for (int k = 0; k < lim && !ok; k++)
    begin
      @(negedge i_ref_clk);
      ok = (o_req_ready === 1'b1);
      tick;
    end
    i_req_valid = 1'b0;
    tick;
  endtask

  task automatic recv(output logic [33:0] r);
    logic got;
    got = 1'b0;
    i_rsp_ready = 1'b1;
    for (int k = 0; k < 400 && !got; k++)
    begin
      @(negedge i_ref_clk);
      got = (o_rsp_valid === 1'b1);
      r = {o_rsp_fault, o_rsp_periph, o_rsp_data};
      tick;
    end
    i_rsp_ready = 1'b0;
    tick;
    if (!got)
      timeout("response");
  endtask

  task automatic do_read(input logic [23:0] a, input logic [1:0] sz, input logic [2:0] sp,
    input logic [33:0] exp, input logic [7:0] n_exp);
    logic ok;
    logic [33:0] r;
    logic [7:0] n0;
    n0 = n_cyc;
    send(a, sz, sp, 400, ok);
    if (!ok)
      timeout("request");
    recv(r);
    chk("response", exp, r);
    chk("bus cycles", {26'h0, n_exp}, {26'h0, 8'(n_cyc - n0)});
    chk("space code", {31'h0, sp}, {31'h0, seen_space});
  endtask

  task automatic t_mode;
    for (int m = 1; m >= 0; m--)
    begin
      i_reset = 1'b1;
      i_width_select_n = m[0];
      repeat (8) tick;
      i_reset = 1'b0;
      repeat (6) tick;
      chk("byte mode", {33'h0, !m[0]}, {33'h0, o_byte_mode});
    end
    chk("upper strobe", 34'h1, {33'h0, o_upper_byte_strobe_n});
  endtask

  task automatic t_sizes;
    logic [2:0] sp [5];
    logic [23:0] a;
    logic [1:0] sz;
    sp = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
    for (int i = 0; i < 5; i++)
    begin
      a = 24'(24'h0100fd + 24'h000111 * i);
      sz = 2'(i % 3);
      do_read(a, sz, sp[i], {2'h0, exp_data(a, sz)}, (sz == 2'h0) ? 8'h1 : ((sz == 2'h1) ? 8'h2 : 8'h4));
    end
  endtask

  task automatic t_waits;
    delay = 4'h9;
    do_read(24'h0200fe, 2'h2, 3'h5, {2'h0, exp_data(24'h0200fe, 2'h2)}, 8'h4);
    delay = 4'h0;
  endtask

  task automatic t_faults;
    mode = 2'h1;
    do_read(24'h000301, 2'h0, 3'h1, {2'h2, 32'h0}, 8'h1);
    mode = 2'h2;
    do_read(24'h000302, 2'h0, 3'h2, {2'h1, 32'h0}, 8'h1);
    mode = 2'h3;
    do_read(24'h000303, 2'h0, 3'h6, {2'h0, exp_data(24'h000303, 2'h0)}, 8'h2);
    mode = 2'h0;
  endtask

  task automatic t_stall;
    logic ok1, ok2, ok3;
    logic [33:0] r;
    delay = 4'h3;
    send(24'h000040, 2'h0, 3'h5, 400, ok1);
    send(24'h000041, 2'h1, 3'h5, 400, ok2);
    send(24'h000042, 2'h0, 3'h5, 60, ok3);
    chk("taken while free", 34'h3, {32'h0, ok1, ok2});
    chk("taken while full", 34'h0, {33'h0, ok3});
    recv(r);
    chk("first result", {2'h0, exp_data(24'h000040, 2'h0)}, r);
    recv(r);
    chk("second result", {2'h0, exp_data(24'h000041, 2'h1)}, r);
    send(24'h000042, 2'h0, 3'h5, 400, ok3);
    recv(r);
    chk("third result", {2'h0, exp_data(24'h000042, 2'h0)}, r);
    delay = 4'h0;
  endtask

  initial
  begin
    n_fail = 0;
    checks = 0;
    i_reset = 1'b1;
    i_width_select_n = 1'b0;
    i_req_valid = 1'b0;
    i_rsp_ready = 1'b0;
    i_req_addr = 24'h0;
    i_req_size = 2'h0;
    i_req_space = 3'h1;
    mode = 2'h0;
    delay = 4'h0;
    t_mode;
    t_sizes;
    t_waits;
    t_faults;
    t_stall;
    results;
  end
endmodule
